// File: arf_clamp.sv
// Rounding and saturating clamp of the wide filter result
`timescale 1ns/10ps
module arf_clamp
   import arf_pkg::*;
#(
   parameter int IN_W  = 24,
   parameter int OUT_W = 17
) (
   input  wire logic [IN_W-1:0]  filt_i,
   output logic      [OUT_W-1:0] code_o
);
   localparam int SH = IN_W - OUT_W;
   logic signed [IN_W:0]  rnd;
   logic signed [IN_W:0]  q;
   logic signed [IN_W:0]  maxv;
   logic signed [IN_W:0]  minv;
   always_comb begin
      rnd  = {filt_i[IN_W-1], filt_i};
      rnd  = rnd + (SH > 0 ? ((IN_W+1)'(1) <<< (SH-1)) : '0);
      q    = rnd >>> SH;
      maxv = (IN_W+1)'((1 <<< (OUT_W-1)) - 1);
      minv = -maxv - (IN_W+1)'(1);
      if (q > maxv) begin
         code_o = {1'b0, {(OUT_W-1){1'b1}}};
      end else if (q < minv) begin
         code_o = {1'b1, {(OUT_W-1){1'b0}}};
      end else begin
         code_o = q[OUT_W-1:0];
      end
   end
endmodule

// File: arf_host_model.sv
// Host model: select pulses and result shift-out reads
`timescale 1ns/10ps
module arf_host_model (
   input  wire logic        clk_i,
   input  wire logic        sdo_i,
   output logic             cs_n_o,
   output logic             read_req_o,
   output logic             shift_en_o,
   output logic             done_o,
   output logic [31:0]      word_o
);
   initial begin
      cs_n_o = 1'b0;
      read_req_o = 1'b0;
      shift_en_o = 1'b0;
      done_o = 1'b0;
      word_o = 32'h0;
   end
   // ----------------------------------------
   // Host tasks
   // ----------------------------------------
   task automatic pulse_cs();
      @(posedge clk_i);
      #2 cs_n_o = 1'b1;
      @(posedge clk_i);
      #2 cs_n_o = 1'b0;
   endtask
   task automatic read(input int nbits, input int gap);
      @(posedge clk_i);
      #2 read_req_o = 1'b1;
      @(posedge clk_i);
      #2 read_req_o = 1'b0;
      word_o = 32'h0;
      for (int i = 0; i < nbits; i++) begin
         shift_en_o = 1'b1;
         @(posedge clk_i);
         #1 word_o = {word_o[30:0], sdo_i};
         if (gap > 0) begin
            #1 shift_en_o = 1'b0;
            repeat (gap) @(posedge clk_i);
            #2;
         end else #1;
      end
      shift_en_o = 1'b0;
      done_o = 1'b1;
      @(posedge clk_i);
      #2 done_o = 1'b0;
   endtask
endmodule

// File: arf_pkg.sv
// Constants for the result formatter and supply reset block
package arf_pkg;
   // ----------------------------------------
   // Format select codes
   // ----------------------------------------
   localparam logic [1:0] ARF_FMT_16      = 2'h0;
   localparam logic [1:0] ARF_FMT_32_LEFT = 2'h1;
   localparam logic [1:0] ARF_FMT_32_SIGN = 2'h2;
   localparam logic [1:0] ARF_FMT_32_TAG  = 2'h3;
   localparam int         ARF_FMT_WIDE_BIT = 1;
   // ----------------------------------------
   // Widths and clamp codes
   // ----------------------------------------
   localparam int          ARF_CODE_W   = 16;
   localparam int          ARF_WIDE_W   = 17;
   localparam int          ARF_TAG_W    = 4;
   localparam int          ARF_FILT_W   = 24;
   localparam logic [15:0] ARF_POS16    = 16'h7FFF;
   localparam logic [15:0] ARF_NEG16    = 16'h8000;
   localparam logic [16:0] ARF_POS17    = 17'h0FFFF;
   localparam logic [16:0] ARF_NEG17    = 17'h10000;
   localparam logic [3:0]  ARF_TAG_MUX  = 4'h0;
   localparam logic [31:0] ARF_RES_RST  = 32'h0000_0000;
   localparam logic [1:0]  ARF_FMT_RST  = 2'h0;
   localparam logic [2:0]  ARF_BYTES_16 = 3'h2;
   localparam logic [2:0]  ARF_BYTES_32 = 3'h4;
   localparam logic [2:0]  ARF_BIT_LAST = 3'h7;
endpackage

// File: arf_top.sv
// Result formatter, supply reset state and result shift-out
// Functional notes
// - Four layouts, one 16-bit, three 32-bit
// - Format 0x gives 16-bit signed, no overrange
// - 16-bit clamps at 7FFF and 8000
// - Format 00 returns only 16 bits
// - Format 01 left-justified, low bytes zero
// - Format 1x 17-bit clamps 0FFFF, 10000
// - 16-bit code is the 17-bit code saturated
// - Format 10 right-justified, sign-filled top
// - Format 11 puts channel tag in top nibble
// - Single-channel mode forces tag to 0000
// - Low supply holds reset, interface off
// - Leave reset when both supplies good
// - Full shutdown: no power-on interrupt
// - Select rise resets port, fall clears irq
// - Result register at 0x0, 16-bit default
// - Filter result rounded to nearest step
// - Result kept until power reset or full reset
`timescale 1ns/10ps
module arf_top
   import arf_pkg::*;
#(
   parameter int FILT_W = ARF_FILT_W
) (
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   input  wire logic              avdd_good_i,
   input  wire logic              dvdd_good_i,
   input  wire logic              full_shutdown_i,
   input  wire logic              full_reset_cmd_i,
   input  wire logic [1:0]        format_sel_i,
   input  wire logic              format_wr_i,
   input  wire logic              single_channel_select_mode_i,
   input  wire logic [3:0]        scan_channel_i,
   input  wire logic [FILT_W-1:0] filt_data_i,
   input  wire logic              filt_valid_i,
   input  wire logic              cs_n_i,
   input  wire logic              read_req_i,
   input  wire logic              shift_en_i,
   output logic                   sdo_o,
   output logic                   shift_busy_o,
   output logic                   por_irq_n_o,
   output logic                   spi_enable_o,
   output logic [1:0]             format_o,
   output logic [31:0]            conversion_result_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic        por;
      logic        irq_pend;
      logic        cs_d;
      logic        cs_armed;
      logic [1:0]  fmt;
      logic [16:0] code;
      logic [3:0]  tag;
      logic [31:0] shreg;
      logic [2:0]  bytes;
      logic [2:0]  bitc;
      logic        busy;
      logic        sdo;
   } arf_state_t;
   arf_state_t st_reg;
   arf_state_t st_next;
   logic [16:0] clamp17;
   logic [15:0] code16;
   logic [31:0] word;
   logic        supply_low;
   // ----------------------------------------
   // Rounding and clamp
   // ----------------------------------------
   arf_clamp #(
      .IN_W  (FILT_W),
      .OUT_W (ARF_WIDE_W)
   ) u_clamp (
      .filt_i (filt_data_i),
      .code_o (clamp17)
   );
   // ----------------------------------------
   // Formatting
   // ----------------------------------------
   always_comb begin
      // 16-bit view of the stored 17-bit code
      if (st_reg.code[16] != st_reg.code[15]) begin
         code16 = st_reg.code[16] ? ARF_NEG16 : ARF_POS16;
      end else begin
         code16 = st_reg.code[15:0];
      end
      unique case (st_reg.fmt)
         ARF_FMT_16:      word = {16'h0000, code16};
         ARF_FMT_32_LEFT: word = {code16, 16'h0000};
         ARF_FMT_32_SIGN: word = {{15{st_reg.code[16]}}, st_reg.code};
         ARF_FMT_32_TAG:  word = {st_reg.tag, {11{st_reg.code[16]}},
                                  st_reg.code};
      endcase
   end
   assign supply_low = !(avdd_good_i && dvdd_good_i) && !full_shutdown_i;
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.cs_d = cs_n_i;
      if (filt_valid_i && !st_reg.por) begin
         st_next.code = clamp17;
         st_next.tag = single_channel_select_mode_i ? ARF_TAG_MUX
                                                    : scan_channel_i;
      end
      if (full_reset_cmd_i && !st_reg.por) begin
         st_next.code = '0;
         st_next.fmt  = ARF_FMT_RST;
      end
      if (format_wr_i && !st_reg.por) begin
         st_next.fmt = format_sel_i;
      end
      if (cs_n_i && !st_reg.cs_d) begin
         st_next.busy     = 1'b0;
         st_next.cs_armed = 1'b1;
      end
      if (!cs_n_i && st_reg.cs_d && st_reg.cs_armed) begin
         st_next.irq_pend = 1'b0;
      end
      if (!st_reg.por && st_reg.cs_armed && !cs_n_i) begin
         if (read_req_i && !st_reg.busy) begin
            st_next.busy  = 1'b1;
            st_next.shreg = (st_reg.fmt[ARF_FMT_WIDE_BIT] ||
                             st_reg.fmt == ARF_FMT_32_LEFT) ? word
                            : {word[15:0], 16'h0000};
            st_next.bytes = (st_reg.fmt == ARF_FMT_16) ? ARF_BYTES_16
                                                       : ARF_BYTES_32;
            st_next.bitc  = ARF_BIT_LAST;
         end else if (shift_en_i && st_reg.busy) begin
            st_next.sdo   = st_reg.shreg[31];
            st_next.shreg = {st_reg.shreg[30:0], 1'b0};
            if (st_reg.bitc == 3'h0) begin
               st_next.bitc  = ARF_BIT_LAST;
               st_next.bytes = st_reg.bytes - 3'h1;
               if (st_reg.bytes == 3'h1) begin
                  st_next.busy = 1'b0;
               end
            end else begin
               st_next.bitc = st_reg.bitc - 3'h1;
            end
         end
      end
      st_next.por = supply_low;
      if (supply_low) begin
         st_next          = '0;
         st_next.por      = 1'b1;
         st_next.irq_pend = 1'b1;
         st_next.cs_d     = cs_n_i;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_reg          <= '0;
         st_reg.por      <= 1'b1;
         st_reg.irq_pend <= 1'b1;
         st_reg.cs_d     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end
   assign sdo_o               = st_reg.sdo;
   assign shift_busy_o        = st_reg.busy;
   assign por_irq_n_o         = !st_reg.irq_pend;
   assign spi_enable_o        = !st_reg.por;
   assign format_o            = st_reg.fmt;
   assign conversion_result_o = word;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_POR_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      supply_low |=> st_reg.por && !spi_enable_o && st_reg.code == '0)
      else $error("reset state not held");
   AST_POR_EXIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      st_reg.por && avdd_good_i && dvdd_good_i |=> spi_enable_o)
      else $error("reset state not left");
   AST_SHUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      full_shutdown_i && !st_reg.por |=> !st_reg.por)
      else $error("reset during full shutdown");
   AST_IRQ_CLR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !supply_low && st_reg.cs_armed && st_reg.cs_d && !cs_n_i |=> por_irq_n_o)
      else $error("irq not cleared");
   AST_CS_RISE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !supply_low && cs_n_i && !st_reg.cs_d |=> !shift_busy_o)
      else $error("port not reset on select rise");
   AST_FMT00: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      format_o == ARF_FMT_16 |-> conversion_result_o[31:16] == 16'h0000)
      else $error("16-bit layout upper half nonzero");
   AST_FMT01: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      format_o == ARF_FMT_32_LEFT |-> conversion_result_o[15:0] == 16'h0000)
      else $error("left layout low bytes nonzero");
   AST_SAT16: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      format_o == ARF_FMT_16 && st_reg.code > 17'h07FFF && !st_reg.code[16]
      |-> conversion_result_o[15:0] == ARF_POS16)
      else $error("16-bit positive clamp wrong");
   AST_TAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      filt_valid_i && single_channel_select_mode_i && !supply_low
      && !st_reg.por && !full_reset_cmd_i |=> st_reg.tag == ARF_TAG_MUX)
      else $error("tag not zero in single mode");
   AST_SIGN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      format_o == ARF_FMT_32_SIGN
      |-> conversion_result_o[31:17] == {15{conversion_result_o[16]}})
      else $error("sign fill wrong");
   AST_LEN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !shift_busy_o ##1 shift_busy_o && format_o == ARF_FMT_16
      |-> st_reg.bytes == ARF_BYTES_16)
      else $error("byte count wrong");
   COV_READ16: cover property (@(posedge clk_sys_i)
      shift_busy_o && format_o == ARF_FMT_16);
   COV_READ32: cover property (@(posedge clk_sys_i)
      shift_busy_o && format_o == ARF_FMT_32_TAG);
   COV_IRQCLR: cover property (@(posedge clk_sys_i)
      !por_irq_n_o ##1 por_irq_n_o);
   COV_PORUP: cover property (@(posedge clk_sys_i)
      !spi_enable_o ##1 spi_enable_o);
endmodule

// File: arf_top_test.sv
// Self-checking bench for the result formatter and supply reset block
`timescale 1ns/10ps
module arf_top_test;
   import arf_pkg::*;
   logic clk_sys_i, reset_i, avdd_good_i, dvdd_good_i, full_shutdown_i;
   logic full_reset_cmd_i, format_wr_i, single_channel_select_mode_i;
   logic filt_valid_i, cs_n_i, read_req_i, shift_en_i, sdo_o, done;
   logic shift_busy_o, por_irq_n_o, spi_enable_o, vld_q = 1'b0;
   logic [1:0]  format_sel_i, format_o, fmt_cur;
   logic [3:0]  scan_channel_i;
   logic [23:0] filt_data_i;
   logic [31:0] conversion_result_o, word, last;
   logic [31:0] exp_q[$];
   logic [23:0] bnd[5] = '{24'h7FFFFF, 24'h800000, 24'h3FFFC0,
                           24'h000040, 24'hBFFF00};
   int          n_errors = 0, checks_done = 0, cycles = 0;
   wire  [31:0] res = conversion_result_o;
   arf_top i_arf_top (.clk_sys_i, .reset_i, .avdd_good_i, .dvdd_good_i,
      .full_shutdown_i, .full_reset_cmd_i, .format_sel_i, .format_wr_i,
      .single_channel_select_mode_i, .scan_channel_i, .filt_data_i,
      .filt_valid_i, .cs_n_i, .read_req_i, .shift_en_i, .sdo_o,
      .shift_busy_o, .por_irq_n_o, .spi_enable_o, .format_o,
      .conversion_result_o);
   arf_host_model i_arf_host_model (.clk_i(clk_sys_i), .sdo_i(sdo_o),
      .cs_n_o(cs_n_i), .read_req_o(read_req_i), .shift_en_o(shift_en_i),
      .done_o(done), .word_o(word));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask
   function automatic logic [31:0] exp_word(input logic [1:0] fm,
      input logic [23:0] f, input logic [3:0] t);
      int v;
      logic [16:0] c;
      logic [15:0] h;
      v = ($signed(f) + 64) >>> 7;
      if (v > 65535) v = 65535;
      c = v[16:0];
      h = v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
      case (fm)
         2'h0: return {16'h0, h};
         2'h1: return {h, 16'h0};
         2'h2: return {{15{c[16]}}, c};
         default: return {t, {11{c[16]}}, c};
      endcase
   endfunction
   task automatic feed(input logic [23:0] f);
      single_channel_select_mode_i = 1'($urandom);
      scan_channel_i = 4'($urandom);
      filt_data_i = f;
      filt_valid_i = 1'b1;
      last = exp_word(fmt_cur, f,
         single_channel_select_mode_i ? 4'h0 : scan_channel_i);
      exp_q.push_back(last);
      step(1);
      filt_valid_i = 1'b0;
      step(1);
   endtask
   // ----------------------------------------
   // Clock, monitor and stimulus
   // ----------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles++;
      vld_q <= filt_valid_i;
      if (vld_q) check(res, exp_q.pop_front());
      if (done) check(word, exp_q.pop_front());
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      {reset_i, avdd_good_i, dvdd_good_i, full_shutdown_i} = 4'h8;
      {full_reset_cmd_i, format_wr_i, filt_valid_i} = 3'h0;
      {format_sel_i, fmt_cur, scan_channel_i} = 8'h0;
      {single_channel_select_mode_i, filt_data_i} = 25'h0;
      void'($urandom(32'hF19F));
      step(6);
      reset_i = 1'b0;
      avdd_good_i = 1'b1;
      step(3);
      check(spi_enable_o, 1'b0);
      check(por_irq_n_o, 1'b0);
      dvdd_good_i = 1'b1;
      step(2);
      check(spi_enable_o, 1'b1);
      check(format_o, ARF_FMT_RST);
      check(conversion_result_o, ARF_RES_RST);
      exp_q.push_back(32'h0);
      i_arf_host_model.read(0, 0);
      check(shift_busy_o, 1'b0);
      i_arf_host_model.pulse_cs();
      step(2);
      check(por_irq_n_o, 1'b1);
      for (int fm = 0; fm < 4; fm++) begin
         format_sel_i = fm[1:0];
         fmt_cur = fm[1:0];
         format_wr_i = 1'b1;
         step(1);
         format_wr_i = 1'b0;
         check(format_o, fmt_cur);
         for (int k = 0; k < 8; k++) feed(k < 5 ? bnd[k] : 24'($urandom));
         exp_q.push_back(last);
         i_arf_host_model.read(fm == 0 ? 16 : 32, fm);
         check(shift_busy_o, 1'b0);
      end
      full_reset_cmd_i = 1'b1;
      step(1);
      full_reset_cmd_i = 1'b0;
      fmt_cur = ARF_FMT_RST;
      check(conversion_result_o, ARF_RES_RST);
      check(format_o, ARF_FMT_RST);
      feed(24'h123400);
      full_shutdown_i = 1'b1;
      dvdd_good_i = 1'b0;
      step(2);
      check(spi_enable_o, 1'b1);
      check(por_irq_n_o, 1'b1);
      check(conversion_result_o, last);
      full_shutdown_i = 1'b0;
      avdd_good_i = 1'b0;
      step(2);
      check(spi_enable_o, 1'b0);
      check(por_irq_n_o, 1'b0);
      check(conversion_result_o, ARF_RES_RST);
      dvdd_good_i = 1'b1;
      step(2);
      check(spi_enable_o, 1'b0);
      avdd_good_i = 1'b1;
      step(2);
      check(spi_enable_o, 1'b1);
      check(format_o, ARF_FMT_RST);
      check(conversion_result_o, ARF_RES_RST);
      i_arf_host_model.pulse_cs();
      step(2);
      check(por_irq_n_o, 1'b1);
      final_report();
   end
endmodule
